// ### rtl/gpd_device.sv
// Device end of an instrument bus port: addressing, remote/local, lockout,
// device clear, abort, service request and serial poll status.
// Assumes bus bytes arrive already handshaken, one per i_bus_valid pulse,
// and all inputs are synchronous to i_clock. Registers sit on APB.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "gpd_regs.svh"

// Interface overview
// Bus bytes: one cycle per byte, i_atn marks commands.
// Commands act on the edge that sees i_bus_valid.
// State changes show in the cycle that follows that edge.
// Abort (i_ifc) is a level and beats any command on talk, listen and poll state.
// Enable (i_ren) low forces local and drops lockout.
// Remote only after own listen address with enable high.
// Local key ignored while lockout holds.
// Listen-only: address 31, no addressing, panel kept alive.
// Listen-only still takes data bytes into the receive register.
//
// Talker path
// Poll byte takes priority over queued data.
// One status byte per poll; a second needs a new enable.
// Queued data byte leaves on valid and ready at an edge.
// Writing a new byte while one waits overwrites it.
//
// Service request
// Level output, stays while a masked-in condition is pending.
// Poll does not clear it; software clears conditions.
// Condition set beats a software clear in one cycle.
// Mask bit 6 is ignored, bit 6 is the request flag itself.
//
// Register side
// APB, no wait states, pready tied high.
// Unmapped offsets answer an error and change nothing.
// Eight-bit registers sit in bits 7:0, upper bits read zero.
// Write data wider than a field is cut to that field.
// Reading the receive register frees it for the next byte.
//
// Address store
// First edge after reset loads the address.
// Backup store first, internal switch if the backup is lost.
// Panel entry writes the store with a one-cycle strobe.
// Entry keeps two digits; values above 31 are dropped.
// Entry in service mode turns controller capability off.
// Limitation: a panel entry drops the addressed state,
// so the controller must address the port again.
//
// Device clear
// One-cycle pulse to the parser, both buffers emptied.
// Universal clear acts in any addressed state.
// Selected clear only when listening with enable high.

module gpd_device (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Instrument bus, after the handshake
    input  wire logic        i_bus_valid,
    input  wire logic [7:0]  i_bus_data,
    input  wire logic        i_atn,
    input  wire logic        i_ifc,
    input  wire logic        i_ren,
    output logic             o_srq,
    output logic             o_listen,
    output logic             o_talk,
    output logic             o_remote,
    output logic             o_talk_valid,
    output logic      [7:0]  o_talk_data,
    input  wire logic        i_talk_ready,
    // Instrument side
    input  wire logic [7:0]  i_cond_set,
    output logic             o_dev_clear,
    // Front panel
    input  wire logic        i_local_key,
    input  wire logic        i_address_entry_key,
    input  wire logic        i_digit_valid,
    input  wire logic [3:0]  i_digit,
    input  wire logic        i_terminator,
    input  wire logic        i_service_mode,
    output logic             o_panel_enable,
    // Battery-backed address store and internal switch
    input  wire logic        i_backup_valid,
    input  wire logic [4:0]  i_stored_addr,
    input  wire logic [4:0]  i_switch_addr,
    output logic             o_store_wr,
    output logic      [4:0]  o_store_addr
);
    import gpd_pkg::*;

    gpd_state_t s;
    gpd_state_t next_s;

    logic       lonly;
    logic [6:0] cmd;
    logic       is_cmd;
    logic       is_data;
    logic [7:0] stb;
    logic       service_requested_bit;
    logic       wr_en;
    logic       rd_en;
    logic       mapped;
    logic [7:0] ent_next;
    logic       tx_take;

    // Address 31 turns addressing off and the port listens to everything
    assign lonly   = (s.addr == `GPD_ADDR_LISTEN_ONLY);
    assign cmd     = i_bus_data[6:0];
    assign is_cmd  = i_bus_valid & i_atn;
    assign is_data = i_bus_valid & ~i_atn;

    // Pending conditions are only requested where the mask lets them
    assign service_requested_bit = |(s.cond & s.mask & 8'hBF);

    // Status byte: condition bits with the request flag in bit 6
    always_comb begin
        stb = s.cond;
        stb[`GPD_STB_RQS] = service_requested_bit;
    end

    // Talker answers the poll with the status byte, otherwise queued data
    assign o_talk_valid = s.talk & (s.spoll | s.tx_full);
    assign o_talk_data  = s.spoll ? stb : s.tx_data;
    assign tx_take      = o_talk_valid & i_talk_ready;

    // Outputs from state
    assign o_srq          = service_requested_bit;
    assign o_listen       = s.listen | lonly;
    assign o_talk         = s.talk;
    assign o_remote       = s.remote;
    assign o_dev_clear    = s.dev_clear;
    assign o_store_wr     = s.store_wr;
    assign o_store_addr   = s.addr;
    // Panel dead in remote; listen-only keeps it alive
    assign o_panel_enable = ~s.remote | lonly;

    // APB decode: no wait states, unmapped offsets answer an error
    assign mapped = (i_paddr == `GPD_REG_CTRL)   | (i_paddr == `GPD_REG_STATUS) |
                    (i_paddr == `GPD_REG_MASK)   | (i_paddr == `GPD_REG_COND)   |
                    (i_paddr == `GPD_REG_TXDATA) | (i_paddr == `GPD_REG_RXDATA);
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~mapped;
    assign wr_en     = i_psel & i_penable & i_pwrite & mapped;
    assign rd_en     = i_psel & i_penable & ~i_pwrite & mapped;

    // Read mux; reserved bits read zero
    always_comb begin
        o_prdata = 32'h0000_0000;
        case (i_paddr)
            `GPD_REG_CTRL:   o_prdata[`GPD_CTRL_CTL_EN] = s.ctl_en;
            `GPD_REG_STATUS: begin
                o_prdata[`GPD_ST_LISTEN]  = s.listen | lonly;
                o_prdata[`GPD_ST_TALK]    = s.talk;
                o_prdata[`GPD_ST_REMOTE]  = s.remote;
                o_prdata[`GPD_ST_LOCKOUT] = s.lockout;
                o_prdata[`GPD_ST_LONLY]   = lonly;
                o_prdata[`GPD_ST_SPOLL]   = s.spoll;
                o_prdata[`GPD_ST_RXFULL]  = s.rx_full;
                o_prdata[`GPD_ST_TXFULL]  = s.tx_full;
                o_prdata[`GPD_ST_ADDR_LSB +: 5] = s.addr;
            end
            `GPD_REG_MASK:   o_prdata[7:0] = s.mask;
            `GPD_REG_COND:   o_prdata[7:0] = stb;
            `GPD_REG_TXDATA: o_prdata[7:0] = s.tx_data;
            `GPD_REG_RXDATA: o_prdata[7:0] = s.rx_data;
            default:         o_prdata = 32'h0000_0000;
        endcase
    end

    // Two decimal digits at most, so the sum stays below 100
    assign ent_next = 8'(s.ent_val * 7'd10) + {4'h0, i_digit};

    // Next-state logic
    always_comb begin
        next_s = s;
        next_s.dev_clear = 1'b0;
        next_s.store_wr  = 1'b0;

        // Software side of the register file
        if (wr_en) begin
            case (i_paddr)
                `GPD_REG_CTRL:   next_s.ctl_en = i_pwdata[`GPD_CTRL_CTL_EN];
                `GPD_REG_MASK:   next_s.mask   = i_pwdata[7:0];
                `GPD_REG_COND:   next_s.cond   = s.cond & ~i_pwdata[7:0];
                `GPD_REG_TXDATA: begin
                    next_s.tx_data = i_pwdata[7:0];
                    next_s.tx_full = 1'b1;
                end
                default: next_s = next_s;
            endcase
        end
        // Reading the receive register frees it for the next byte
        if (rd_en && (i_paddr == `GPD_REG_RXDATA)) begin
            next_s.rx_full = 1'b0;
        end

        // Instrument events win over a clear in the same cycle
        next_s.cond = next_s.cond | i_cond_set;

        // Talker byte leaves; a poll byte is sent once
        if (tx_take) begin
            if (s.spoll) begin
                next_s.spoll = 1'b0;
            end else begin
                // A byte written in the same cycle keeps the flag set
                next_s.tx_full = wr_en && (i_paddr == `GPD_REG_TXDATA);
            end
        end

        // Incoming data bytes go to the parser while listening
        if (is_data && (s.listen || lonly) && !s.rx_full) begin
            next_s.rx_data = i_bus_data;
            next_s.rx_full = 1'b1;
        end

        // Bus commands
        if (is_cmd) begin
            case (cmd)
                `GPD_CMD_UNL: next_s.listen = 1'b0;
                `GPD_CMD_UNT: next_s.talk   = 1'b0;
                `GPD_CMD_SPE: next_s.spoll  = 1'b1;
                `GPD_CMD_SPD: next_s.spoll  = 1'b0;
                `GPD_CMD_LLO: next_s.lockout = 1'b1;
                `GPD_CMD_DCL: begin
                    next_s.talk      = 1'b0;
                    next_s.dev_clear = 1'b1;
                    next_s.rx_full   = 1'b0;
                    next_s.tx_full   = 1'b0;
                end
                `GPD_CMD_SDC: begin
                    if (s.listen && i_ren) begin
                        next_s.talk      = 1'b0;
                        next_s.dev_clear = 1'b1;
                        next_s.rx_full   = 1'b0;
                        next_s.tx_full   = 1'b0;
                    end
                end
                `GPD_CMD_GTL: begin
                    if (s.listen && i_ren) begin
                        next_s.talk   = 1'b0;
                        next_s.remote = 1'b0;
                    end
                end
                default: begin
                    // Own listen address: needs a normal address
                    if (!lonly && cmd[6:5] == `GPD_GRP_LISTEN
                        && cmd[4:0] == s.addr) begin
                        next_s.listen = 1'b1;
                        if (i_ren) begin
                            next_s.talk   = 1'b0;
                            next_s.remote = 1'b1;
                        end
                    end
                    // Talk addresses: own one takes the bus, others free it
                    if (!lonly && cmd[6:5] == `GPD_GRP_TALK) begin
                        if (cmd[4:0] == s.addr) begin
                            next_s.talk   = 1'b1;
                            next_s.listen = 1'b0;
                        end else begin
                            next_s.talk = 1'b0;
                        end
                    end
                end
            endcase
        end

        // Local key honoured only without lockout
        if (i_local_key && s.remote && !s.lockout) begin
            next_s.remote = 1'b0;
        end

        // REN false: back to local and lockout cleared
        if (!i_ren) begin
            next_s.remote  = 1'b0;
            next_s.lockout = 1'b0;
        end

        // Abort overrides any command on talk, listen and poll state
        if (i_ifc) begin
            next_s.talk   = 1'b0;
            next_s.listen = 1'b0;
            next_s.spoll  = 1'b0;
        end

        // Address load and front-panel entry
        case (s.fsm)
            GPD_ST_INIT: begin
                // Backup store if it survived, else the internal switch
                next_s.addr = i_backup_valid ? i_stored_addr : i_switch_addr;
                next_s.fsm  = GPD_ST_RUN;
            end
            GPD_ST_RUN: begin
                if (i_address_entry_key && o_panel_enable) begin
                    next_s.ent_val = 7'h00;
                    next_s.ent_cnt = 2'h0;
                    next_s.fsm     = GPD_ST_ENTRY;
                end
            end
            GPD_ST_ENTRY: begin
                if (i_digit_valid && s.ent_cnt != 2'h2) begin
                    next_s.ent_val = ent_next[6:0];
                    next_s.ent_cnt = s.ent_cnt + 2'h1;
                end else if (i_terminator) begin
                    // Out-of-range entries are dropped, address unchanged
                    if ({1'b0, s.ent_val} <= `GPD_ENTRY_MAX && s.ent_cnt != 2'h0) begin
                        next_s.addr     = s.ent_val[4:0];
                        next_s.store_wr = 1'b1;
                        next_s.listen   = 1'b0;
                        next_s.talk     = 1'b0;
                        if (i_service_mode) begin
                            next_s.ctl_en = 1'b0;
                        end
                    end
                    next_s.fsm = GPD_ST_RUN;
                end
            end
            default: next_s.fsm = GPD_ST_RUN;
        endcase
    end

    // State register; address starts at the delivered default
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s           <= '0;
            s.fsm       <= GPD_ST_INIT;
            s.addr      <= `GPD_ADDR_DEFAULT;
            s.mask      <= `GPD_MASK_RESET;
            s.cond      <= `GPD_COND_RESET;
            s.remote    <= 1'b0;
            s.lockout   <= 1'b0;
            s.listen    <= 1'b0;
            s.talk      <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

endmodule : gpd_device

`default_nettype wire

// ### rtl/gpd_regs.svh
// Constants for the instrument bus device port: addresses, bus commands,
// register offsets, field positions and reset values.
// Assumes it is included by bare name from the package and the design.
`ifndef GPD_REGS_SVH
`define GPD_REGS_SVH

// Bus address values
`define GPD_ADDR_DEFAULT     5'h13
`define GPD_ADDR_LISTEN_ONLY 5'h1F
`define GPD_ENTRY_MAX        8'h1F

// Bus commands, seven bits with ATN true
`define GPD_CMD_GTL          7'h01
`define GPD_CMD_SDC          7'h04
`define GPD_CMD_LLO          7'h11
`define GPD_CMD_DCL          7'h14
`define GPD_CMD_SPE          7'h18
`define GPD_CMD_SPD          7'h19
`define GPD_CMD_UNL          7'h3F
`define GPD_CMD_UNT          7'h5F
`define GPD_GRP_LISTEN       2'h1
`define GPD_GRP_TALK         2'h2

// Register offsets (byte addresses)
`define GPD_REG_CTRL         12'h000
`define GPD_REG_STATUS       12'h004
`define GPD_REG_MASK         12'h008
`define GPD_REG_COND         12'h00C
`define GPD_REG_TXDATA       12'h010
`define GPD_REG_RXDATA       12'h014

// Field positions
`define GPD_CTRL_CTL_EN      0
`define GPD_ST_LISTEN        0
`define GPD_ST_TALK          1
`define GPD_ST_REMOTE        2
`define GPD_ST_LOCKOUT       3
`define GPD_ST_LONLY         4
`define GPD_ST_SPOLL         5
`define GPD_ST_RXFULL        6
`define GPD_ST_TXFULL        7
`define GPD_ST_ADDR_LSB      8
`define GPD_STB_RQS          6

// Reset values
`define GPD_MASK_RESET       8'h00
`define GPD_COND_RESET       8'h00

`endif

// ### rtl/gpd_pkg.sv
// Types for the instrument bus device port.
// Assumes the constants header sits beside it.
`default_nettype none
`include "gpd_regs.svh"

package gpd_pkg;

    // Top-level sequencing, one-hot
    typedef enum logic [2:0] {
        GPD_ST_INIT  = 3'b001,
        GPD_ST_RUN   = 3'b010,
        GPD_ST_ENTRY = 3'b100
    } gpd_fsm_t;

    // Whole state of the device port
    typedef struct packed {
        gpd_fsm_t    fsm;
        logic [4:0]  addr;
        logic        listen;
        logic        talk;
        logic        remote;
        logic        lockout;
        logic        spoll;
        logic        ctl_en;
        logic [7:0]  mask;
        logic [7:0]  cond;
        logic [7:0]  tx_data;
        logic        tx_full;
        logic [7:0]  rx_data;
        logic        rx_full;
        logic [6:0]  ent_val;
        logic [1:0]  ent_cnt;
        logic        dev_clear;
        logic        store_wr;
    } gpd_state_t;

endpackage : gpd_pkg

`default_nettype wire

// ### tb/gpd_device_checker.sv
// Concurrent checks on the instrument bus device port.
// Assumes it is bound onto gpd_device and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module gpd_device_checker (
    // Clock and reset
    input wire logic       i_clock,
    input wire logic       i_rst_b,
    // Bus side
    input wire logic       i_bus_valid,
    input wire logic [7:0] i_bus_data,
    input wire logic       i_atn,
    input wire logic       i_ifc,
    input wire logic       i_ren,
    // Observed state
    input wire logic       o_listen,
    input wire logic       o_talk,
    input wire logic       o_remote,
    input wire logic       o_talk_valid,
    input wire logic       o_dev_clear,
    input wire logic       o_panel_enable,
    input wire logic [4:0] o_store_addr
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    // Command strobe; abort in the same cycle wins, so it is left out
    logic cmd;
    logic mine;
    assign cmd  = i_bus_valid && i_atn && !i_ifc;
    assign mine = o_store_addr != 5'h1F;

    AST_ABORT: assert property (i_ifc |=> !o_talk && !o_listen || !mine)
        else $error("abort left an addressed state");
    AST_LISTEN: assert property (cmd && mine && i_ren
        && i_bus_data[6:0] == {2'h1, o_store_addr} |=> o_listen && !o_talk && o_remote)
        else $error("listen address not honoured");
    AST_TALK: assert property (cmd && mine
        && i_bus_data[6:0] == {2'h2, o_store_addr} |=> o_talk && !o_listen)
        else $error("talk address not honoured");
    AST_DCL: assert property (cmd && i_bus_data[6:0] == 7'h14 |=> o_dev_clear && !o_talk)
        else $error("universal clear missed");
    AST_SDC: assert property (cmd && mine && o_listen && i_ren
        && i_bus_data[6:0] == 7'h04 |=> o_dev_clear && !o_talk)
        else $error("selected clear missed");
    AST_GTL: assert property (cmd && mine && o_listen && i_ren
        && i_bus_data[6:0] == 7'h01 |=> !o_remote && !o_talk)
        else $error("go to local missed");
    // Raw command strobe: a listen address beside an abort may still set remote
    AST_WAIT: assert property (!o_remote && !(i_bus_valid && i_atn
        && i_bus_data[6:5] == 2'h1) |=> !o_remote)
        else $error("remote without listen address");
    AST_REN: assert property (!i_ren |=> !o_remote)
        else $error("remote kept with enable low");
    AST_PANEL: assert property (o_panel_enable == (!o_remote || !mine))
        else $error("panel enable wrong");
    AST_TXV: assert property (o_talk_valid |-> o_talk)
        else $error("talk data offered while not talker");
endmodule : gpd_device_checker

bind gpd_device gpd_device_checker u_chk (.*);

`default_nettype wire

// ### tb/gpd_ctl_model.sv
// Bus controller model: sends bytes, drives enable and abort, takes talk bytes.
// Assumes the device samples its inputs on the rising edge of i_clock.
`timescale 1ns/1ps
`default_nettype none

module gpd_ctl_model (
    // Clock
    input wire logic       i_clock,
    // Controller outputs
    output logic           o_bus_valid,
    output logic           o_atn,
    output logic           o_ifc,
    output logic           o_ren,
    output logic           o_talk_ready,
    output logic     [7:0] o_bus_data,
    // Talker from device
    input wire logic       i_talk_valid,
    input wire logic [7:0] i_talk_data
);
    // Idle bus at time zero
    initial begin
        o_bus_valid  = 1'h0;
        o_atn        = 1'h0;
        o_ifc        = 1'h0;
        o_ren        = 1'h0;
        o_talk_ready = 1'h0;
        o_bus_data   = 8'h00;
    end

    // One byte; data flips after so a stale byte never looks valid
    task send(input logic atn, input logic [7:0] v);
        @(posedge i_clock);
        o_bus_valid <= 1'h1;
        o_atn       <= atn;
        o_bus_data  <= v;
        @(posedge i_clock);
        o_bus_valid <= 1'h0;
        o_atn       <= 1'h0;
        o_bus_data  <= ~v;
        #1;
    endtask : send

    // Enable level, held one edge so the device sees it
    task set_ren(input logic v);
        @(posedge i_clock);
        o_ren <= v;
        @(posedge i_clock);
        #1;
    endtask : set_ren

    // Abort pulse
    task abort;
        @(posedge i_clock);
        o_ifc <= 1'h1;
        @(posedge i_clock);
        o_ifc <= 1'h0;
        #1;
    endtask : abort

    // Accept one talk byte after d idle cycles
    task take(input int d, output logic [7:0] v);
        repeat (d) @(posedge i_clock);
        o_talk_ready <= 1'h1;
        for (int k = 0; k < 40; k++) begin
            @(posedge i_clock);
            if (i_talk_valid === 1'h1) break;
        end
        v = i_talk_data;
        o_talk_ready <= 1'h0;
        #1;
    endtask : take
endmodule : gpd_ctl_model

`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the instrument bus device port.
// Assumes the bound checker and the controller model beside it.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // Design signals, named as the ports
    logic        i_clock, i_rst_b, i_psel, i_penable, i_pwrite, i_service_mode;
    logic        i_local_key, i_address_entry_key, i_digit_valid, i_terminator;
    logic        i_bus_valid, i_atn, i_ifc, i_ren, i_talk_ready, i_backup_valid;
    logic        o_pready, o_pslverr, o_srq, o_listen, o_talk, o_remote, o_store_wr;
    logic        o_talk_valid, o_dev_clear, o_panel_enable, err;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, r;
    logic [7:0]  i_bus_data, o_talk_data, i_cond_set, b;
    logic [3:0]  i_digit;
    logic [4:0]  i_stored_addr, i_switch_addr, o_store_addr;
    int          n_fail, checks;

    gpd_device i_dut (.*);
    gpd_ctl_model u_ctl (
        .i_clock      (i_clock),
        .o_bus_valid  (i_bus_valid),
        .o_atn        (i_atn),
        .o_ifc        (i_ifc),
        .o_ren        (i_ren),
        .o_talk_ready (i_talk_ready),
        .o_bus_data   (i_bus_data),
        .i_talk_valid (o_talk_valid),
        .i_talk_data  (o_talk_data)
    );

    initial begin
        i_clock = 1'h0;
        forever #20 i_clock = ~i_clock;
    end

    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    // One APB transfer; waits on pready, no bound of its own
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_psel   <= 1'h1;
        i_pwrite <= w;
        i_paddr  <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'h1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge i_clock);
        end while (o_pready !== 1'h1);
        r = o_prdata;
        err = o_pslverr;
        i_psel    <= 1'h0;
        i_penable <= 1'h0;
        #1;
    endtask : apb

    // Panel pulse: bit0 local, bit1 entry, bit2 digit, bit3 terminator
    task pan(input logic [3:0] p, input logic [3:0] v);
        @(posedge i_clock);
        {i_terminator, i_digit_valid, i_address_entry_key, i_local_key} <= p;
        i_digit <= v;
        @(posedge i_clock);
        {i_terminator, i_digit_valid, i_address_entry_key, i_local_key} <= 4'h0;
        #1;
    endtask : pan

    task enter(input logic [3:0] hi, input logic [3:0] lo);
        pan(4'h2, 4'h0);
        pan(4'h4, hi);
        pan(4'h4, lo);
        pan(4'h8, 4'h0);
    endtask : enter

    task cset(input logic [7:0] v);
        @(posedge i_clock);
        i_cond_set <= v;
        @(posedge i_clock);
        i_cond_set <= 8'h00;
        #1;
    endtask : cset

    task wrap_up;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    // Whole run is near 150 cycles; forty times that means a hang
    initial begin
        #240000;
        n_fail++;
        wrap_up;
    end

    initial begin
        {i_rst_b, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        {i_terminator, i_digit_valid, i_address_entry_key, i_local_key} = 4'h0;
        {i_digit, i_cond_set, i_service_mode, i_backup_valid} = '0;
        i_stored_addr = 5'h0A;
        i_switch_addr = 5'h13;
        repeat (10) @(posedge i_clock);
        chk({o_listen, o_talk, o_remote, o_panel_enable}, 4'h1);
        chk(o_store_addr, 5'h13);
        i_rst_b <= 1'h1;
        repeat (2) @(posedge i_clock);
        apb(1'h0, 12'h004, 32'h0);
        chk(r[12:0], 13'h1300);
        apb(1'h0, 12'h008, 32'h0);
        chk(r, 32'h0);
        u_ctl.set_ren(1'h1);
        chk(o_remote, 1'h0);
        u_ctl.send(1'h1, 8'h33);
        chk({o_listen, o_talk, o_remote, o_panel_enable}, 4'hA);
        u_ctl.send(1'h0, 8'h5A);
        apb(1'h0, 12'h014, 32'h0);
        chk(r, 32'h5A);
        // Lockout holds remote against the local key
        u_ctl.send(1'h1, 8'h11);
        pan(4'h1, 4'h0);
        apb(1'h0, 12'h004, 32'h0);
        chk(r[3:2], 2'h3);
        u_ctl.set_ren(1'h0);
        apb(1'h0, 12'h004, 32'h0);
        chk(r[3:2], 2'h0);
        u_ctl.set_ren(1'h1);
        u_ctl.send(1'h1, 8'h33);
        pan(4'h1, 4'h0);
        chk(o_remote, 1'h0);
        // Talker with a slow controller, then clears
        u_ctl.send(1'h1, 8'h53);
        chk({o_listen, o_talk}, 2'h1);
        apb(1'h1, 12'h010, 32'hA5);
        u_ctl.take(3, b);
        chk(b, 8'hA5);
        u_ctl.send(1'h1, 8'h14);
        chk({o_dev_clear, o_talk}, 2'h2);
        u_ctl.send(1'h1, 8'h33);
        u_ctl.send(1'h1, 8'h04);
        chk(o_dev_clear, 1'h1);
        u_ctl.send(1'h1, 8'h01);
        chk(o_remote, 1'h0);
        u_ctl.abort;
        chk({o_listen, o_talk}, 2'h0);
        // Service request only through the mask, then a poll
        cset(8'h02);
        chk(o_srq, 1'h0);
        apb(1'h1, 12'h008, 32'h01);
        cset(8'h01);
        chk(o_srq, 1'h1);
        u_ctl.send(1'h1, 8'h18);
        u_ctl.send(1'h1, 8'h53);
        u_ctl.take(0, b);
        chk(b[6], 1'h1);
        chk(o_talk_valid, 1'h0);
        u_ctl.send(1'h1, 8'h19);
        u_ctl.send(1'h1, 8'h5F);
        chk(o_talk, 1'h0);
        apb(1'h1, 12'h00C, 32'h03);
        chk(o_srq, 1'h0);
        // Panel address entry in service mode
        apb(1'h1, 12'h000, 32'h1);
        @(posedge i_clock);
        i_service_mode <= 1'h1;
        enter(4'h3, 4'h2);
        chk(o_store_wr, 1'h0);
        enter(4'h2, 4'h5);
        chk({o_store_wr, o_store_addr}, 6'h39);
        apb(1'h0, 12'h000, 32'h0);
        chk(r[0], 1'h0);
        u_ctl.send(1'h1, 8'h39);
        chk(o_listen, 1'h1);
        u_ctl.send(1'h1, 8'h01);
        u_ctl.send(1'h1, 8'h3F);
        chk(o_listen, 1'h0);
        enter(4'h3, 4'h1);
        chk({o_listen, o_panel_enable}, 2'h3);
        u_ctl.send(1'h0, 8'h3C);
        apb(1'h0, 12'h014, 32'h0);
        chk(r, 32'h3C);
        apb(1'h0, 12'h018, 32'h0);
        chk(err, 1'h1);
        // Second power-up with the backed-up address intact
        @(posedge i_clock);
        i_rst_b <= 1'h0;
        i_backup_valid <= 1'h1;
        @(posedge i_clock);
        i_rst_b <= 1'h1;
        repeat (2) @(posedge i_clock);
        apb(1'h0, 12'h004, 32'h0);
        chk(r[12:8], 5'h0A);
        // Third power-up with the backup lost: the switch value wins
        @(posedge i_clock);
        i_rst_b <= 1'h0;
        i_backup_valid <= 1'h0;
        i_switch_addr <= 5'h07;
        @(posedge i_clock);
        i_rst_b <= 1'h1;
        repeat (2) @(posedge i_clock);
        apb(1'h0, 12'h004, 32'h0);
        chk(r[12:8], 5'h07);
        wrap_up;
    end
endmodule : testbench

`default_nettype wire
